// ---- flash_seq_host.v ----
// Host-side programming and erase sequencer for a byte-wide command-register flash.
// Assumes the flash pins are wired directly and the user side is on the same clock.
`timescale 1ns/100ps
`include "flash_seq_consts.vh"
// Behaviour
// R1: C0H ends pulse, selects program verify
// R2: Verify write strobe terminates programming
// R3: Verify write carries no new address
// R4: Verify read returns margin-sensed byte
// R5: Compare verify data, then next byte
// R6: Any byte order, always verify each
// R7: Two FFH writes abort set-up
// R8: Follow abort with a valid command
// R9: Program pulse lasts 10 us
// R10: Pulse and verify, up to 25
// R11: Blank array skips erasure entirely
// R12: Preprogram whole array to 00H
// R13: Erase verify from 0000H to first failure
// R14: Resume verify from last verified address
// R15: Device powers up in read mode
// R16: Write only with both strobes low
// R17: Two-step sequence before array change
// R18: 40H arms, next write programs
// R19: 20H twice starts erase
// R20: A0H ends erase, latches verify address
// R21: Report failure after pulse limit
// R22: Finish with read command
module flash_seq_host #(
   parameter ADDR_WIDTH   = 18,
   parameter PULSE_CYCLES = `PROG_PULSE_CYCLES,
   parameter ERASE_CYCLES = `ERASE_PULSE_CYCLES,
   parameter MAX_PULSES   = `MAX_PROG_PULSES,
   parameter MAX_ERASES   = `MAX_ERASE_PULSES
)(
   // Clock and reset
   input  wire                  clock,
   input  wire                  resetn,
   // User request
   input  wire                  req_valid,
   output wire                  req_ready,
   input  wire [1:0]            req_op,
   input  wire [ADDR_WIDTH-1:0] req_addr,
   input  wire [7:0]            req_data,
   // User result
   output reg                   result_valid,
   output reg                   result_fail,
   output reg  [7:0]            result_data,
   output reg  [ADDR_WIDTH-1:0] result_addr,
   // Flash pins
   output wire [ADDR_WIDTH-1:0] flash_addr,
   output wire [7:0]            flash_dq_out,
   output wire                  flash_dq_oe,
   input  wire [7:0]            flash_dq_in,
   output wire                  chip_enable_n,
   output wire                  write_enable_n,
   output wire                  output_enable_n
);
   localparam S_IDLE      = 4'h0;
   localparam S_PROG_SET  = 4'h1;
   localparam S_PROG_WR   = 4'h2;
   localparam S_PULSE     = 4'h3;
   localparam S_PVERIFY   = 4'h4;
   localparam S_PREAD     = 4'h5;
   localparam S_BLANK_RD  = 4'h6;
   localparam S_ERASE_SET = 4'h7;
   localparam S_ERASE_WR  = 4'h8;
   localparam S_EPULSE    = 4'h9;
   localparam S_EVERIFY   = 4'hA;
   localparam S_EREAD     = 4'hB;
   localparam S_RESET2    = 4'hC;
   localparam S_READ_CMD  = 4'hD;
   localparam S_ARRAY_RD  = 4'hE;
   localparam S_FINISH    = 4'hF;

   reg  [3:0]            state;
   reg  [1:0]            op;
   reg                   preprog;
   reg                   fail;
   reg  [ADDR_WIDTH-1:0] addr;
   reg  [7:0]            target;
   reg  [31:0]           timer;
   reg  [15:0]           pulses;
   reg                   cyc_start;
   reg                   cyc_read;
   reg  [ADDR_WIDTH-1:0] cyc_addr;
   reg  [7:0]            cyc_data;
   wire                  cyc_done;
   wire [7:0]            cyc_rdata;
   wire                  last_addr = (addr == {ADDR_WIDTH{1'b1}});

   assign req_ready = (state == S_IDLE) && !result_valid;

   flash_bus_cycle #(.ADDR_WIDTH(ADDR_WIDTH)) bus (
      .clock           (clock),
      .resetn          (resetn),
      .start           (cyc_start),
      .is_read         (cyc_read),
      .addr            (cyc_addr),
      .wdata           (cyc_data),
      .done            (cyc_done),
      .rdata           (cyc_rdata),
      .flash_addr      (flash_addr),
      .flash_dq_out    (flash_dq_out),
      .flash_dq_oe     (flash_dq_oe),
      .flash_dq_in     (flash_dq_in),
      .chip_enable_n   (chip_enable_n),
      .write_enable_n  (write_enable_n),
      .output_enable_n (output_enable_n)
   );

   // Bus cycle to issue in each state
   always @*
   begin
      cyc_start = 1'b0;
      cyc_read  = 1'b0;
      cyc_addr  = addr;
      cyc_data  = `CMD_READ;
      case (state)
         S_PROG_SET:  begin cyc_start = 1'b1; cyc_data = `CMD_PROGRAM; end // see R18
         S_PROG_WR:   begin cyc_start = 1'b1; cyc_data = target; end // see R17
         S_PVERIFY:   begin cyc_start = 1'b1; cyc_data = `CMD_PROG_VERIFY; end // see R1
         S_PREAD:     begin cyc_start = 1'b1; cyc_read = 1'b1; end // see R4
         S_BLANK_RD:  begin cyc_start = 1'b1; cyc_read = 1'b1; end // see R11
         S_ERASE_SET: begin cyc_start = 1'b1; cyc_data = `CMD_ERASE; end // see R19
         S_ERASE_WR:  begin cyc_start = 1'b1; cyc_data = `CMD_ERASE; end // see R19
         S_EVERIFY:   begin cyc_start = 1'b1; cyc_data = `CMD_ERASE_VERIFY; end // see R20
         S_EREAD:     begin cyc_start = 1'b1; cyc_read = 1'b1; end
         S_RESET2:    begin cyc_start = 1'b1; cyc_data = `CMD_RESET; end // see R7
         S_READ_CMD:  begin cyc_start = 1'b1; cyc_data = `CMD_READ; end // see R22
         S_ARRAY_RD:  begin cyc_start = 1'b1; cyc_read = 1'b1; end
         default:     cyc_start = 1'b0;
      endcase
   end

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state        <= S_IDLE;
         op           <= `OP_READ;
         preprog      <= 1'b0;
         fail         <= 1'b0;
         addr         <= {ADDR_WIDTH{1'b0}};
         target       <= 8'h00;
         timer        <= 32'h00000000;
         pulses       <= 16'h0000;
         result_valid <= 1'b0;
         result_fail  <= 1'b0;
         result_data  <= 8'h00;
         result_addr  <= {ADDR_WIDTH{1'b0}};
      end
      else
      begin
         result_valid <= 1'b0;
         case (state)
            S_IDLE:
               if (req_valid && req_ready)
               begin
                  op      <= req_op;
                  addr    <= req_addr;
                  target  <= req_data;
                  pulses  <= 16'h0000;
                  fail    <= 1'b0;
                  preprog <= 1'b0;
                  case (req_op)
                     `OP_PROGRAM: state <= S_PROG_SET; // see R6
                     `OP_ERASE:
                     begin
                        addr  <= {ADDR_WIDTH{1'b0}};
                        state <= S_READ_CMD;
                     end
                     `OP_ABORT:   state <= S_RESET2;
                     default:     state <= S_READ_CMD;
                  endcase
               end
            // Each of these steps moves on to the state coded one above it
            S_PROG_SET, S_ERASE_SET, S_PVERIFY, S_EVERIFY:
               if (cyc_done) // see R2 see R3
                  state <= state + 4'h1;
            S_PROG_WR, S_ERASE_WR:
               if (cyc_done)
               begin
                  pulses <= pulses + 16'h0001;
                  timer  <= 32'h00000000;
                  state  <= state + 4'h1;
               end
            S_PULSE, S_EPULSE:
               if (timer >= ((state == S_PULSE) ? PULSE_CYCLES : ERASE_CYCLES) - 1) // see R9
                  state <= state + 4'h1;
               else
                  timer <= timer + 32'h00000001;
            S_PREAD:
               if (cyc_done)
               begin
                  if (cyc_rdata == target) // see R5
                  begin
                     pulses <= 16'h0000;
                     if (!preprog)
                        state <= S_READ_CMD;
                     else if (last_addr)
                     begin
                        preprog <= 1'b0;
                        addr    <= {ADDR_WIDTH{1'b0}};
                        state   <= S_ERASE_SET;
                     end
                     else
                     begin
                        addr  <= addr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
                        state <= S_PROG_SET;
                     end
                  end
                  else if (pulses >= MAX_PULSES) // see R10 see R21
                  begin
                     fail  <= 1'b1;
                     state <= S_READ_CMD;
                  end
                  else
                     state <= S_PROG_SET;
               end
            S_BLANK_RD:
               if (cyc_done)
               begin
                  if (cyc_rdata != `DATA_ERASED) // see R12
                  begin
                     preprog <= 1'b1;
                     addr    <= {ADDR_WIDTH{1'b0}};
                     pulses  <= 16'h0000;
                     target  <= `DATA_ZERO;
                     state   <= S_PROG_SET;
                  end
                  else if (last_addr)
                     state <= S_READ_CMD; // see R11
                  else
                     addr <= addr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
               end
            S_EREAD:
               if (cyc_done)
               begin
                  if (cyc_rdata == `DATA_ERASED)
                  begin
                     if (last_addr) // see R13
                        state <= S_READ_CMD;
                     else
                     begin
                        addr  <= addr + {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
                        state <= S_EVERIFY;
                     end
                  end
                  else if (pulses >= MAX_ERASES) // see R21
                  begin
                     fail  <= 1'b1;
                     state <= S_READ_CMD;
                  end
                  else
                     state <= S_ERASE_SET; // see R14
               end
            S_RESET2:
               if (cyc_done)
               begin
                  if (pulses == 16'h0001)
                     state <= S_READ_CMD; // see R8
                  else
                     pulses <= 16'h0001;
               end
            S_READ_CMD:
               if (cyc_done)
               begin
                  if (op == `OP_ERASE && !fail && !preprog && pulses == 16'h0000)
                  begin
                     pulses <= 16'hFFFF;
                     state  <= S_BLANK_RD;
                  end
                  else if (op == `OP_READ)
                     state <= S_ARRAY_RD;
                  else
                     state <= S_FINISH;
               end
            S_ARRAY_RD:
               if (cyc_done)
               begin
                  target <= cyc_rdata;
                  state  <= S_FINISH;
               end
            S_FINISH:
            begin
               result_valid <= 1'b1;
               result_fail  <= fail;
               result_data  <= target;
               result_addr  <= addr;
               state        <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule

// ---- flash_seq_consts.vh ----
// Command codes and timing counts for the byte-wide flash programming controller.
// Assumes a 100 MHz system clock; included by the controller and its bus cycle engine.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
`define CMD_READ          8'h00
`define CMD_ERASE         8'h20
`define CMD_ERASE_VERIFY  8'hA0
`define CMD_PROGRAM       8'h40
`define CMD_PROG_VERIFY   8'hC0
`define CMD_RESET         8'hFF
`define DATA_ERASED       8'hFF
`define DATA_ZERO         8'h00
`define CLOCK_MHZ         100
`define PROG_PULSE_NS     10000
`define PROG_PULSE_CYCLES (`PROG_PULSE_NS * `CLOCK_MHZ / 1000)
`define ERASE_PULSE_CYCLES 1000000
`define MAX_PROG_PULSES   25
`define MAX_ERASE_PULSES  1000
`define STROBE_CYCLES     4'h4
`define READ_CYCLES       4'h8
`define OP_PROGRAM        2'h0
`define OP_ERASE          2'h1
`define OP_ABORT          2'h2
`define OP_READ           2'h3
`endif

// ---- flash_bus_cycle.v ----
// One write or read cycle on the flash parallel bus.
// Assumes the flash latches address on write strobe fall and data on its rise.
`timescale 1ns/100ps
`include "flash_seq_consts.vh"
module flash_bus_cycle #(
   parameter ADDR_WIDTH = 18
)(
   // Clock and reset
   input  wire                  clock,
   input  wire                  resetn,
   // Request
   input  wire                  start,
   input  wire                  is_read,
   input  wire [ADDR_WIDTH-1:0] addr,
   input  wire [7:0]            wdata,
   output wire                  done,
   output reg  [7:0]            rdata,
   // Flash pins
   output reg  [ADDR_WIDTH-1:0] flash_addr,
   output reg  [7:0]            flash_dq_out,
   output reg                   flash_dq_oe,
   input  wire [7:0]            flash_dq_in,
   output reg                   chip_enable_n,
   output reg                   write_enable_n,
   output reg                   output_enable_n
);
   reg  [3:0] count;
   reg        busy;
   reg        reading;
   reg  [7:0] dq_meta;
   reg  [7:0] dq_sync;
   wire [3:0] last = reading ? `READ_CYCLES : `STROBE_CYCLES;

   assign done = busy && (count == last);

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         count           <= 4'h0;
         busy            <= 1'b0;
         reading         <= 1'b0;
         rdata           <= 8'h00;
         flash_addr      <= {ADDR_WIDTH{1'b0}};
         flash_dq_out    <= 8'h00;
         flash_dq_oe     <= 1'b0;
         chip_enable_n   <= 1'b1;
         write_enable_n  <= 1'b1;
         output_enable_n <= 1'b1;
         dq_meta         <= 8'h00;
         dq_sync         <= 8'h00;
      end
      else
      begin
         dq_meta <= flash_dq_in;
         dq_sync <= dq_meta;
         if (start && !busy)
         begin
            busy         <= 1'b1;
            reading      <= is_read;
            count        <= 4'h0;
            flash_addr   <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe  <= !is_read;
         end
         else if (busy)
         begin
            count <= count + 4'h1;
            // Strobes low only together; otherwise held high to inhibit writes (see R16)
            chip_enable_n   <= (count >= last - 4'h1);
            write_enable_n  <= reading || (count >= last - 4'h1);
            output_enable_n <= !reading || (count >= last - 4'h1);
            if (done)
            begin
               busy        <= 1'b0;
               flash_dq_oe <= 1'b0;
            end
            if (reading && count == last - 4'h1)
               rdata <= dq_sync;
         end
      end
   end
endmodule

// ---- flash_seq_host_checker.sv ----
// Port-level checks on the flash sequencer's strobes, pulses and results.
// Assumes it is bound onto flash_seq_host with the same pulse parameters.
`timescale 1ns/100ps
module flash_seq_host_checker #(
   parameter ADDR_WIDTH   = 18,
   parameter PULSE_CYCLES = 1000,
   parameter MAX_PULSES   = 25
)(
   // Clock and reset
   input wire logic       clock,
   input wire logic       resetn,
   // User result
   input wire logic       result_valid,
   // Flash pins
   input wire logic [ADDR_WIDTH-1:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   input wire logic       flash_dq_oe,
   input wire logic       chip_enable_n,
   input wire logic       write_enable_n,
   input wire logic       output_enable_n
);
   logic        we_q;
   logic [7:0]  wdat;
   logic [7:0]  c1;
   logic [7:0]  c2;
   logic [1:0]  st;
   logic [31:0] cnt;
   logic [31:0] npulse;
   logic [ADDR_WIDTH-1:0] paddr;
   wire         we_rise = write_enable_n && !we_q;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   // Track the last written bytes and the program pulse state
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         we_q <= 1'b1;
         wdat <= 8'h00;
         c1 <= 8'h00;
         c2 <= 8'h00;
         st <= 2'h0;
         cnt <= 32'h0;
         npulse <= 32'h0;
         paddr <= {ADDR_WIDTH{1'b0}};
      end
      else
      begin
         we_q <= write_enable_n;
         if (!write_enable_n)
            wdat <= flash_dq_out;
         cnt <= we_rise ? 32'h0 : cnt + 32'h1;
         if (we_rise)
         begin
            c1 <= wdat;
            c2 <= c1;
            st <= (st == 2'h1 && wdat != 8'hFF) ? 2'h2 : ((wdat == 8'h40) ? 2'h1 : 2'h0);
         end
         if (result_valid)
            npulse <= 32'h0;
         else if (we_rise && st == 2'h1 && wdat != 8'hFF)
            npulse <= (flash_addr == paddr) ? npulse + 32'h1 : 32'h1;
         // Pulses are counted per byte: a new address starts a new count
         if (we_rise && st == 2'h1 && wdat != 8'hFF)
            paddr <= flash_addr;
      end
   end
   AST_WE_CE: assert property (!write_enable_n |-> !chip_enable_n)
      else $error("write strobe without chip enable");
   AST_WE_OE: assert property (!write_enable_n |-> output_enable_n && flash_dq_oe)
      else $error("write strobe while reading or not driving");
   AST_PULSE_LEN: assert property (we_rise && st == 2'h2 |-> cnt >= PULSE_CYCLES - 1 && cnt <= PULSE_CYCLES + 40)
      else $error("program pulse length out of range");
   AST_VERIFY_AFTER: assert property (we_rise && st == 2'h2 |-> wdat == 8'hC0)
      else $error("program write not followed by verify");
   AST_PULSE_MAX: assert property (we_rise && st == 2'h2 |-> npulse <= MAX_PULSES)
      else $error("too many program pulses");
   AST_ABORT_NEXT: assert property (we_rise && c1 == 8'hFF && c2 == 8'hFF |-> wdat == 8'h00)
      else $error("no command after abort");
   AST_FINISH_READ: assert property (result_valid |-> (we_rise ? wdat : c1) == 8'h00)
      else $error("result without read command");
   AST_RESULT_ONE: assert property (result_valid |=> !result_valid)
      else $error("result pulse longer than one cycle");
endmodule
bind flash_seq_host flash_seq_host_checker #(
   .ADDR_WIDTH   (ADDR_WIDTH),
   .PULSE_CYCLES (PULSE_CYCLES),
   .MAX_PULSES   (MAX_PULSES)
) chk_u (
   .clock           (clock),
   .resetn          (resetn),
   .result_valid    (result_valid),
   .flash_addr      (flash_addr),
   .flash_dq_out    (flash_dq_out),
   .flash_dq_oe     (flash_dq_oe),
   .chip_enable_n   (chip_enable_n),
   .write_enable_n  (write_enable_n),
   .output_enable_n (output_enable_n)
);

// ---- flash_dev_model.sv ----
// Behavioural byte-wide command-register flash for the sequencer bench.
// Assumes active-low strobes from the host; the data pins are merged here.
`timescale 1ns/100ps
module flash_dev_model #(
   parameter AW = 4
)(
   // Host pins
   input  wire [AW-1:0] addr,
   input  wire [7:0]    din,
   input  wire          host_oe,
   output wire [7:0]    dout,
   input  wire          ce_n,
   input  wire          we_n,
   input  wire          oe_n
);
   reg [7:0]    mem [0:(1<<AW)-1];
   reg [7:0]    cmd;
   reg [7:0]    pd;
   reg [7:0]    lastv;
   reg [AW-1:0] ca;
   reg [AW-1:0] pa;
   reg [AW-1:0] ea;
   reg          stuck;
   integer      need, tries, npul, nerase, erased, i;
   time         t0;
   wire         wr = !ce_n && !we_n;
   wire         rd = !ce_n && !oe_n;
   wire [7:0]   val = (cmd == 8'hC0) ? mem[pa] : ((cmd == 8'hA0) ? mem[ea] : mem[addr]);
   // Released bus shows the inverse of the last value
   assign dout = host_oe ? din : (rd ? val : ~lastv);
   initial
   begin
      cmd = 8'h00;
      stuck = 1'b0;
      pa = 0;
      need = 1;
      tries = 0;
      npul = 0;
      nerase = 0;
      erased = 0;
      lastv = 8'h00;
      for (i = 0; i < (1 << AW); i = i + 1)
         mem[i] = 8'hF0 ^ i[7:0];
   end
   always @(negedge rd)
      lastv = val;
   always @(posedge wr)
      ca = addr;
   always @(negedge wr)
   begin
      if (cmd == 8'h41 && din == 8'hC0)
      begin
         npul = npul + 1;
         if ($time - t0 >= 10000 && !stuck)
            tries = tries + 1;
         if (tries >= need)
            mem[pa] = mem[pa] & pd;
      end
      if (cmd == 8'h21)
      begin
         nerase = nerase + 1;
         erased = erased + 8;
         for (i = 0; i < erased && i < (1 << AW); i = i + 1)
            mem[i] = 8'hFF;
      end
      if (cmd == 8'h40 && din != 8'hFF)
      begin
         if (ca != pa)
            tries = 0;
         pa = ca;
         pd = din;
         t0 = $time;
         erased = 0;
         cmd = 8'h41;
      end
      else if ((cmd == 8'h40 || cmd == 8'h20) && din == 8'hFF)
         cmd = 8'hFE;
      else if (cmd == 8'hFE && din == 8'hFF)
         cmd = 8'hFD;
      else if (cmd == 8'h20 && din == 8'h20)
         cmd = 8'h21;
      else
      begin
         if (din == 8'hA0)
            ea = ca;
         cmd = din;
      end
   end
endmodule

// ---- tb_flash_seq_host.sv ----
// Self-checking bench for the flash sequencer against a behavioural flash.
// Assumes a 100 MHz clock and a shortened erase pulse count.
`timescale 1ns/100ps
module tb_flash_seq_host;
   localparam AW = 4;
   reg           clock, resetn, req_valid;
   reg  [1:0]    req_op;
   reg  [AW-1:0] req_addr;
   reg  [7:0]    req_data;
   wire          req_ready, result_valid, result_fail, flash_dq_oe;
   wire [7:0]    result_data, flash_dq_out, flash_dq_in;
   wire [AW-1:0] result_addr, flash_addr;
   wire          chip_enable_n, write_enable_n, output_enable_n;
   integer       n_errors, checks_done, base, k;
   flash_seq_host #(.ADDR_WIDTH(AW), .PULSE_CYCLES(1000), .ERASE_CYCLES(50)) dut_u (
      .clock(clock), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
      .result_valid(result_valid), .result_fail(result_fail),
      .result_data(result_data), .result_addr(result_addr),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
      .flash_dq_in(flash_dq_in), .chip_enable_n(chip_enable_n),
      .write_enable_n(write_enable_n), .output_enable_n(output_enable_n));
   flash_dev_model #(.AW(AW)) dev_u (
      .addr(flash_addr), .din(flash_dq_out), .host_oe(flash_dq_oe), .dout(flash_dq_in),
      .ce_n(chip_enable_n), .we_n(write_enable_n), .oe_n(output_enable_n));
   task end_of_test;
   begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         n_errors = n_errors + 1;
      end
   end
   endtask
   // One request, held until taken, then wait for its result pulse
   task run(input [1:0] op, input [AW-1:0] a, input [7:0] d);
      reg     ok;
      integer n;
   begin
      req_op = op;
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      ok = 1'b0;
      while (!ok)
      begin
         @(negedge clock) ok = (req_ready === 1'b1);
         @(posedge clock);
      end
      #1 req_valid = 1'b0;
      n = 0;
      while (result_valid !== 1'b1 && n < 40000)
      begin
         @(posedge clock);
         #1 n = n + 1;
      end
      chk(result_valid, 1'b1);
   end
   endtask
   task t_read;
   begin
      run(2'h3, 4'h5, 8'h00);
      chk(result_data, 8'hF5);
      chk(result_addr, 4'h5);
   end
   endtask
   task t_program;
   begin
      dev_u.need = 3;
      base = dev_u.npul;
      run(2'h0, 4'h3, 8'h30);
      chk(result_fail, 1'b0);
      chk(result_data, 8'h30);
      chk(result_addr, 4'h3);
      chk(dev_u.npul - base, 3);
      run(2'h3, 4'h3, 8'h00);
      chk(result_data, 8'h30);
   end
   endtask
   task t_fail;
   begin
      dev_u.stuck = 1'b1;
      base = dev_u.npul;
      run(2'h0, 4'h6, 8'h00);
      chk(result_fail, 1'b1);
      chk(dev_u.npul - base, 25);
      dev_u.stuck = 1'b0;
   end
   endtask
   task t_abort;
   begin
      run(2'h2, 4'h0, 8'h00);
      chk(result_fail, 1'b0);
      run(2'h3, 4'h3, 8'h00);
      chk(result_data, 8'h30);
   end
   endtask
   task t_erase;
   begin
      dev_u.need = 1;
      base = dev_u.nerase;
      run(2'h1, 4'h0, 8'h00);
      chk(result_fail, 1'b0);
      chk(result_addr, 4'hF);
      chk(dev_u.nerase - base, 2);
      for (k = 0; k < (1 << AW); k = k + 1)
      begin
         run(2'h3, k[AW-1:0], 8'h00);
         chk(result_data, 8'hFF);
      end
      base = dev_u.nerase;
      run(2'h1, 4'h0, 8'h00);
      chk(dev_u.nerase - base, 0);
   end
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_op = 2'h0;
      req_addr = 4'h0;
      req_data = 8'h00;
      n_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge clock);
      #1 resetn = 1'b1;
      @(posedge clock);
      #1;
      t_read;
      t_program;
      t_fail;
      t_abort;
      t_erase;
      end_of_test;
   end
   initial
   begin
      #1000000;
      n_errors = n_errors + 1;
      end_of_test;
   end
endmodule
